/* smrb_supervisor.sv */
// Overview of operation
// - Rail above threshold raises power-good immediately
// - Reset releases after 200ms continuous power-good
// - Rail below threshold drops power-good immediately
// - Reset asserts 32us after power-good falls
// - Short power-good highs under 200ms keep reset
// - Short power-good dips under 32us keep reset
// - Threshold chosen from select pin state
// - Select grounded over 32us forces soft reset
// - Reset held 200ms after select released
// - Pumps off until both supplies out of lockout
// - Breaker trips on overcurrent beyond 20us
// - Trip kills gates, fault, power-good; reset later
// - Trip latches until power-cycle or supply loss
// - Aux comparator output low when input below
// - Power-cycle request over 20ms restarts, clears trip
// - Bus disable low with reset release, else high
module smrb_supervisor
    import smrb_pkg::*;
#(
    parameter int RELEASE_COUNT = smrb_pkg::RELEASE_TICKS,
    parameter int CYCLE_COUNT = smrb_pkg::CYCLE_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic railAbove465,
    input wire logic railAbove290,
    input wire logic railAbove588,
    input wire smrb_pkg::smrb_sel_type threshold_select_in,
    input wire logic lowSupplyOk,
    input wire logic highSupplyOk,
    input wire logic low_rail_sense_in,
    input wire logic high_rail_sense_in,
    input wire logic auxCompareAbove,
    input wire logic powerCycleReq_n,
    input wire logic railDischarged,
    output logic power_good_out,
    output logic reset_n,
    output logic busDisable,
    output logic fault_n,
    output logic pump_on_out,
    output logic low_rail_gate_drive,
    output logic high_rail_gate_drive,
    output logic aux_compare_out
);
    import smrb_pkg::*;

    // Counts beyond the timer width are refused inside each timer
    if (RELEASE_COUNT < 1 || CYCLE_COUNT < 1) begin : g_bad_count
        $error("smrb_supervisor counts must be positive");
    end

    // Two-stage synchronisers; only the second stage is used
    localparam int NS = 10;
    // Request bit resets to its idle high so no request is seen at start
    localparam logic [NS-1:0] SYNC_IDLE = NS'(1);
    logic [NS-1:0] syncA, syncB;
    wire [NS-1:0] rawIn = {railAbove465, railAbove290, railAbove588,
        threshold_select_in, lowSupplyOk, highSupplyOk,
        low_rail_sense_in | high_rail_sense_in, auxCompareAbove,
        powerCycleReq_n};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= SYNC_IDLE;
            syncB <= SYNC_IDLE;
        end else begin
            syncA <= rawIn;
            syncB <= syncA;
        end
    end
    wire s465 = syncB[9];
    wire s290 = syncB[8];
    wire s588 = syncB[7];
    wire [1:0] sSel = syncB[6:5];
    wire sLoOk = syncB[4];
    wire sHiOk = syncB[3];
    wire sOver = syncB[2];
    wire sAux = syncB[1];
    wire sCycReq_n = syncB[0];
    // Discharge sense gets its own two-stage synchroniser
    logic dischargedA, dischargedS;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dischargedA <= 1'b0;
            dischargedS <= 1'b0;
        end else begin
            dischargedA <= railDischarged;
            dischargedS <= dischargedA;
        end
    end

    // Free-running time base: one tick per microsecond
    // Tick phase is free, so every timer may start up to a tick late
    logic [4:0] prescale;
    wire tick = prescale == 5'(TICK_CYCLES - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= '0;
        end else begin
            prescale <= tick ? '0 : prescale + 1'b1;
        end
    end

    // Threshold pick; grounded select also triggers soft reset via 5.88V
    wire selGround = sSel == SEL_GROUND;
    wire railAbove = (sSel == SEL_LOW_RAIL) ? s290 :
        selGround ? s588 : s465;

    smrb_state_type state, next_state;
    wire suppliesOk = sLoOk && sHiOk;
    wire running = state == ST_RUN;
    wire pgLevel = running && railAbove;

    // Filters: overcurrent, long power-cycle request, pg low, pg high
    logic tripDone, cycleDone, lowDone, highDone;
    // Overcurrent only counts while running; lockout clears the fault flag
    smrb_qual #(.LIMIT(TRIP_TICKS), .W(CNT_W)) uTrip (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(sOver && running),
        .done(tripDone)
    );
    // A request must outlast the filter; short presses are dropped
    smrb_qual #(.LIMIT(CYCLE_COUNT), .W(CNT_W)) uCycle (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(!sCycReq_n),
        .done(cycleDone)
    );
    // Counting pg low covers both drops and a grounded select pin
    smrb_qual #(.LIMIT(ASSERT_TICKS), .W(CNT_W)) uLow (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(!pgLevel),
        .done(lowDone)
    );
    smrb_qual #(.LIMIT(RELEASE_COUNT), .W(CNT_W)) uHigh (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(pgLevel),
        .done(highDone)
    );

    // ST_CYCLE holds gates off until request released and rail drained
    always_comb begin
        next_state = state;
        unique case (state)
            ST_LOCKOUT: begin
                if (suppliesOk) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!suppliesOk) begin
                    next_state = ST_LOCKOUT;
                end else if (cycleDone) begin
                    next_state = ST_CYCLE;
                end else if (tripDone) begin
                    next_state = ST_TRIPPED;
                end
            end
            ST_TRIPPED: begin
                if (!suppliesOk) begin
                    next_state = ST_LOCKOUT;
                end else if (cycleDone) begin
                    next_state = ST_CYCLE;
                end
            end
            ST_CYCLE: begin
                if (!suppliesOk) begin
                    next_state = ST_LOCKOUT;
                end else if (sCycReq_n && dischargedS) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_LOCKOUT;
        endcase
    end

    // Reset output: high after release delay, low after assert delay
    // Both timers never finish together: pg is either high or low
    logic resetLevel;
    wire next_reset = highDone ? 1'b1 : (lowDone ? 1'b0 : resetLevel);
    wire next_pump = next_state == ST_RUN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_LOCKOUT;
            resetLevel <= 1'b0;
        end else begin
            state <= next_state;
            resetLevel <= next_reset;
        end
    end

    // Registered outputs; pg follows the same cycle as its cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_good_out <= 1'b0;
            reset_n <= 1'b0;
            busDisable <= 1'b1;
            fault_n <= 1'b1;
            pump_on_out <= 1'b0;
            low_rail_gate_drive <= 1'b0;
            high_rail_gate_drive <= 1'b0;
            aux_compare_out <= 1'b0;
        end else begin
            power_good_out <= (next_state == ST_RUN) && railAbove;
            reset_n <= next_reset;
            busDisable <= !next_reset;
            fault_n <= next_state != ST_TRIPPED;
            pump_on_out <= next_pump;
            low_rail_gate_drive <= next_pump;
            high_rail_gate_drive <= next_pump;
            aux_compare_out <= sAux;
        end
    end
endmodule

/* smrb_pkg.sv */
package smrb_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int RELEASE_DELAY_MS = 200;
    localparam int ASSERT_DELAY_US = 32;
    localparam int TRIP_FILTER_US = 20;
    localparam int CYCLE_REQ_MS = 20;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int RELEASE_TICKS = RELEASE_DELAY_MS * 1000 / TICK_US;
    localparam int ASSERT_TICKS = ASSERT_DELAY_US / TICK_US;
    localparam int TRIP_TICKS = TRIP_FILTER_US / TICK_US;
    localparam int CYCLE_TICKS = CYCLE_REQ_MS * 1000 / TICK_US;
    localparam int CNT_W = 18;
    // Threshold-select pin states as reported by the pin sense
    typedef enum logic [1:0] {
        SEL_OPEN = 2'h0,
        SEL_LOW_RAIL = 2'h1,
        SEL_GROUND = 2'h2
    } smrb_sel_type;
    typedef enum logic [3:0] {
        ST_LOCKOUT = 4'h1,
        ST_RUN = 4'h2,
        ST_TRIPPED = 4'h4,
        ST_CYCLE = 4'h8
    } smrb_state_type;
endpackage

/* smrb_qual.sv */
// Counts ticks while a condition holds; done once the count is exceeded
module smrb_qual #(
    parameter int LIMIT = 32,
    parameter int W = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic cond,
    output logic done
);
    logic [W-1:0] count;
    // The first tick may come at once, so LIMIT + 1 ticks prove LIMIT held
    if (LIMIT < 1 || LIMIT >= (1 << W) - 1) begin : g_bad_limit
        $error("smrb_qual LIMIT out of range");
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (tick && count != W'(LIMIT + 1)) begin
            count <= count + 1'b1;
        end
    end
    assign done = cond && count == W'(LIMIT + 1);
endmodule

/* smrb_supervisor_properties.sv */
module smrb_supervisor_checker
    import smrb_pkg::*;
#(
    parameter int RELEASE_COUNT = RELEASE_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic railAbove465,
    input wire logic lowSupplyOk,
    input wire logic highSupplyOk,
    input wire logic low_rail_sense_in,
    input wire logic high_rail_sense_in,
    input wire logic powerCycleReq_n,
    input wire smrb_sel_type threshold_select_in,
    input wire logic power_good_out,
    input wire logic reset_n,
    input wire logic busDisable,
    input wire logic fault_n,
    input wire logic pump_on_out,
    input wire logic low_rail_gate_drive
);
    int pgHi, pgLo, ocHi;
    // Run lengths in clocks; the assert and trip checks allow one tick of slack for the tick jitter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgHi <= 0;
            pgLo <= 0;
            ocHi <= 0;
        end else begin
            pgHi <= power_good_out ? pgHi + 1 : 0;
            pgLo <= power_good_out ? 0 : pgLo + 1;
            ocHi <= low_rail_sense_in | high_rail_sense_in ? ocHi + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pg_rail: assert property (
        power_good_out && $past(threshold_select_in, 3) == SEL_OPEN
        |-> $past(railAbove465, 3)) else $error("pg without rail");
    a_release_hold: assert property (
        $rose(reset_n) |-> pgHi >= RELEASE_COUNT * TICK_CYCLES)
        else $error("early release");
    a_assert_delay: assert property (
        $fell(reset_n) |-> pgLo >= (ASSERT_TICKS - 1) * TICK_CYCLES)
        else $error("early reset");
    a_bus_follow: assert property (busDisable == !reset_n)
        else $error("bus disable wrong");
    a_pump_lockout: assert property (
        pump_on_out |-> $past(lowSupplyOk, 3) && $past(highSupplyOk, 3))
        else $error("pump in lockout");
    a_trip_filter: assert property (
        $fell(fault_n) |-> $past(ocHi, 3) >= (TRIP_TICKS - 1) * TICK_CYCLES)
        else $error("fast trip");
    a_trip_off: assert property (
        !fault_n |-> !low_rail_gate_drive && !power_good_out)
        else $error("on while tripped");
    a_trip_latch: assert property (
        !fault_n && $past(powerCycleReq_n, 2) && $past(lowSupplyOk, 2)
        && $past(highSupplyOk, 2) |=> !fault_n)
        else $error("trip lost");
    c_release: cover property ($rose(reset_n));
    c_trip: cover property ($fell(fault_n));
    c_dip: cover property ($fell(power_good_out) && reset_n);
endmodule

bind smrb_supervisor smrb_supervisor_checker #(
    .RELEASE_COUNT(RELEASE_COUNT)
) i_chk (
    .clk(clk),
    .rst_n(rst_n),
    .railAbove465(railAbove465),
    .lowSupplyOk(lowSupplyOk),
    .highSupplyOk(highSupplyOk),
    .low_rail_sense_in(low_rail_sense_in),
    .high_rail_sense_in(high_rail_sense_in),
    .powerCycleReq_n(powerCycleReq_n),
    .threshold_select_in(threshold_select_in),
    .power_good_out(power_good_out),
    .reset_n(reset_n),
    .busDisable(busDisable),
    .fault_n(fault_n),
    .pump_on_out(pump_on_out),
    .low_rail_gate_drive(low_rail_gate_drive)
);

/* smrb_rail_model.sv */
module smrb_rail_model (
    input wire logic clk,
    input wire logic gateOn,
    input wire logic sag,
    output logic above465,
    output logic above290,
    output logic above588,
    output logic discharged
);
    timeunit 1ns;
    timeprecision 1ns;
    int lvl = 0;
    // Slow slew so power-good trails the gate drive by about 100 clocks
    always @(posedge clk) begin
        if (gateOn) lvl <= lvl < 100 ? lvl + 1 : 100;
        else lvl <= lvl > 0 ? lvl - 1 : 0;
    end
    // A sag leaves the rail between the two lower thresholds
    assign above465 = lvl == 100 && !sag;
    assign above290 = lvl >= 60;
    assign above588 = 1'b0;
    assign discharged = lvl == 0;
endmodule

/* test_supply_monitor_reset_breaker.sv */
module test_supply_monitor_reset_breaker;
    timeunit 1ns;
    timeprecision 1ns;
    import smrb_pkg::*;
    logic clk = 0, rst_n = 0, lowSupplyOk = 0, highSupplyOk = 1, sag = 0;
    logic low_rail_sense_in = 0, high_rail_sense_in = 0, powerCycleReq_n = 1;
    logic auxCompareAbove = 1, railAbove465, railAbove290, railAbove588;
    smrb_sel_type threshold_select_in = SEL_OPEN;
    logic railDischarged, power_good_out, reset_n, busDisable, fault_n;
    logic pump_on_out, low_rail_gate_drive, high_rail_gate_drive;
    logic aux_compare_out;
    int n_errors = 0, num_checks = 0;
    always #25 clk = ~clk;
    smrb_supervisor #(.RELEASE_COUNT(50), .CYCLE_COUNT(30))
        i_smrb_supervisor (
        .clk(clk),
        .rst_n(rst_n),
        .railAbove465(railAbove465),
        .railAbove290(railAbove290),
        .railAbove588(railAbove588),
        .threshold_select_in(threshold_select_in),
        .lowSupplyOk(lowSupplyOk),
        .highSupplyOk(highSupplyOk),
        .low_rail_sense_in(low_rail_sense_in),
        .high_rail_sense_in(high_rail_sense_in),
        .auxCompareAbove(auxCompareAbove),
        .powerCycleReq_n(powerCycleReq_n),
        .railDischarged(railDischarged),
        .power_good_out(power_good_out),
        .reset_n(reset_n),
        .busDisable(busDisable),
        .fault_n(fault_n),
        .pump_on_out(pump_on_out),
        .low_rail_gate_drive(low_rail_gate_drive),
        .high_rail_gate_drive(high_rail_gate_drive),
        .aux_compare_out(aux_compare_out)
    );
    smrb_rail_model i_smrb_rail_model (
        .clk(clk),
        .gateOn(low_rail_gate_drive),
        .sag(sag),
        .above465(railAbove465),
        .above290(railAbove290),
        .above588(railAbove588),
        .discharged(railDischarged)
    );
    task automatic tk(input int n);
        repeat (n * TICK_CYCLES) @(posedge clk);
    endtask
    task automatic ex(input int n, ref logic s, input logic e);
        tk(n);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        tk(1000);
        n_errors++;
        print_verdict();
    end
    initial begin
        int r;
        r = $urandom(32'h13031576);
        repeat (20) @(posedge clk);
        rst_n <= 1;
        ex(5, pump_on_out, 0);
        lowSupplyOk <= 1;
        ex(10, power_good_out, 1);
        ex(30, reset_n, 0);
        ex(30, reset_n, 1);
        ex(0, busDisable, 0);
        r = 1 + $urandom % 20;
        sag <= 1;
        ex(r, power_good_out, 0);
        sag <= 0;
        ex(5, reset_n, 1);
        sag <= 1;
        ex(40, reset_n, 0);
        sag <= 0;
        ex(20, reset_n, 0);
        $display("power and dips done");
        threshold_select_in <= SEL_LOW_RAIL;
        sag <= 1;
        ex(62, power_good_out, 1);
        ex(0, reset_n, 1);
        threshold_select_in <= SEL_GROUND;
        ex(3, power_good_out, 0);
        ex(0, reset_n, 1);
        ex(37, reset_n, 0);
        threshold_select_in <= SEL_OPEN;
        sag <= 0;
        ex(30, reset_n, 0);
        ex(30, reset_n, 1);
        $display("select done");
        r = 1 + $urandom % 18;
        low_rail_sense_in <= 1;
        tk(r);
        low_rail_sense_in <= 0;
        ex(2, fault_n, 1);
        high_rail_sense_in <= 1;
        ex(23, fault_n, 0);
        ex(0, reset_n, 1);
        high_rail_sense_in <= 0;
        ex(40, reset_n, 0);
        powerCycleReq_n <= 0;
        tk(10);
        powerCycleReq_n <= 1;
        ex(40, fault_n, 0);
        powerCycleReq_n <= 0;
        ex(35, fault_n, 1);
        powerCycleReq_n <= 1;
        ex(5, pump_on_out, 1);
        high_rail_sense_in <= 1;
        ex(25, fault_n, 0);
        high_rail_sense_in <= 0;
        highSupplyOk <= 0;
        ex(1, fault_n, 1);
        ex(0, pump_on_out, 0);
        highSupplyOk <= 1;
        ex(5, pump_on_out, 1);
        for (int v = 0; v < 2; v++) begin
            auxCompareAbove <= v[0];
            ex(1, aux_compare_out, v[0]);
        end
        $display("breaker and aux done");
        print_verdict();
    end
endmodule
